// [verilog/lab_defines.vh]
// constants of the limit and alert register bank
// What this block does
// - shunt limit word: upper limit high byte, lower limit low byte, signed
// - one shunt limit count equals 2.56 mV against the shunt reading
// - bus limit word: unsigned upper limit bits 15:8, lower bits 7:0
// - one bus limit count equals 256 mV against the bus reading
// - current word reads as a 16-bit two's-complement value
// - power word reads as an unsigned 16-bit value
// - a warning flag stays 1 until the master writes 1 to it
// - flag 0 bus below lower limit, flag 1 bus above upper limit
// - flag 2 shunt below lower limit, flag 3 shunt above upper limit
// - alert enable bit 7 lets any set flag pull the pin low
// - outside clock enable makes the pin an input and stops the oscillator
// - internal clock is pin frequency over twice (divider plus one)
// - limits are compared once per completed conversion
// - each register word moves as two bytes, high byte first
// - sda falling while scl high opens a transfer; ignored during power-up
// - sda rising while scl high closes a transfer and returns to standby
// - device is slave only, never drives scl, sda starts as input
// - write is address, pointer, two data bytes, each acknowledged
`ifndef LAB_DEFINES_VH
`define LAB_DEFINES_VH

`define LAB_OFS_POWER     8'h03
`define LAB_OFS_CURRENT   8'h04
`define LAB_OFS_SHUNT_LIM 8'h06
`define LAB_OFS_BUS_LIM   8'h07
`define LAB_OFS_FLAGS     8'h08
`define LAB_OFS_AUX       8'h09

`define LAB_LIM_UPPER_MSB 15
`define LAB_LIM_UPPER_LSB 8
`define LAB_LIM_LOWER_MSB 7
`define LAB_LIM_LOWER_LSB 0

`define LAB_FLG_BUS_LOW   0
`define LAB_FLG_BUS_HIGH  1
`define LAB_FLG_SHUNT_LOW 2
`define LAB_FLG_SHUNT_HI  3
`define LAB_FLG_WIDTH     4

`define LAB_AUX_FORCE     8
`define LAB_AUX_ALERT_EN  7
`define LAB_AUX_CLK_EN    6
`define LAB_AUX_DIV_MSB   5
`define LAB_AUX_DIV_LSB   0
`define LAB_AUX_WIDTH     9

`define LAB_RST_LIMIT     16'h0000
`define LAB_RST_FLAGS     4'h0
`define LAB_RST_AUX       9'h000

`define LAB_POR_CYCLES    8'h10

`endif

// [verilog/lab_clk_div.v]
// divider turning the outside clock pin into the internal clock
`timescale 1ns/1ps
module lab_clk_div (
  input  wire       clk_i,
  input  wire       nrst_i,
  input  wire       en_i,
  input  wire       pin_s_i,
  input  wire [5:0] div_i,
  output reg        int_clk_o
);
  reg       pin_prev_q;
  reg [5:0] cnt_q;

  // toggles once every div+1 rising pin edges
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_prev_q <= 1'b0;
      cnt_q      <= 6'h00;
      int_clk_o  <= 1'b0;
    end else begin
      pin_prev_q <= pin_s_i;
      if (!en_i) begin
        cnt_q     <= 6'h00;
        int_clk_o <= 1'b0;
      end else if (pin_s_i && !pin_prev_q) begin
        if (cnt_q == div_i) begin
          cnt_q     <= 6'h00;
          int_clk_o <= ~int_clk_o;
        end else begin
          cnt_q <= cnt_q + 6'h01;
        end
      end
    end
  end
endmodule

// [verilog/lab_bank.v]
// limit and alert register bank with its serial slave port
`timescale 1ns/1ps
`include "lab_defines.vh"
module lab_bank (
  input  wire        clk_i,
  input  wire        nrst_i,
  input  wire        scl_i,
  input  wire        sda_i,
  output wire        sda_o,
  output reg         sda_oe_o,
  input  wire [6:0]  slave_addr_i,
  input  wire        conv_done_i,
  input  wire [15:0] shunt_i,
  input  wire [15:0] bus_i,
  input  wire [15:0] power_i,
  input  wire [15:0] current_i,
  input  wire        alert_or_clock_pin_i,
  output wire        alert_or_clock_pin_o,
  output reg         alert_or_clock_pin_oe_o,
  output reg         osc_run_o,
  output wire        int_clk_o
);
  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_ADDR  = 3'd1;
  localparam [2:0] ST_PTR   = 3'd2;
  localparam [2:0] ST_WDATA = 3'd3;
  localparam [2:0] ST_RDATA = 3'd4;
  localparam [2:0] ST_HOLD  = 3'd5;

  reg  [2:0]  scl_sync_q;
  reg  [2:0]  sda_sync_q;
  reg  [1:0]  pin_sync_q;
  reg  [7:0]  por_cnt_q;
  reg  [2:0]  state_q;
  reg  [3:0]  cnt_q;
  reg  [7:0]  shift_q;
  reg  [7:0]  ptr_q;
  reg  [7:0]  hold_q;
  reg  [15:0] word_q;
  reg         hi_q;
  reg         fresh_q;
  reg  [15:0] shunt_lim_q;
  reg  [15:0] bus_lim_q;
  reg  [3:0]  flags_q;
  reg  [8:0]  aux_q;
  reg         wr_stb_q;
  reg  [15:0] wr_data_q;
  reg  [3:0]  flags_set;
  reg  [3:0]  flags_clr;
  reg  [15:0] next_word;
  reg         next_hi;

  wire por_done  = (por_cnt_q == `LAB_POR_CYCLES);
  wire scl_s     = scl_sync_q[1];
  wire sda_s     = sda_sync_q[1];
  wire scl_rise  = scl_s && !scl_sync_q[2];
  wire scl_fall  = !scl_s && scl_sync_q[2];
  wire start_det = scl_s && scl_sync_q[2] && !sda_s && sda_sync_q[2];
  wire stop_det  = scl_s && scl_sync_q[2] && sda_s && !sda_sync_q[2];
  wire clk_en    = aux_q[`LAB_AUX_CLK_EN];

  // limit and control fields under their own names
  wire [7:0] shunt_upper_limit     = shunt_lim_q[`LAB_LIM_UPPER_MSB:`LAB_LIM_UPPER_LSB];
  wire [7:0] shunt_lower_limit     = shunt_lim_q[`LAB_LIM_LOWER_MSB:`LAB_LIM_LOWER_LSB];
  wire [7:0] bus_upper_limit       = bus_lim_q[`LAB_LIM_UPPER_MSB:`LAB_LIM_UPPER_LSB];
  wire [7:0] bus_lower_limit       = bus_lim_q[`LAB_LIM_LOWER_MSB:`LAB_LIM_LOWER_LSB];
  wire       force_alert           = aux_q[`LAB_AUX_FORCE];
  wire       alert_enable          = aux_q[`LAB_AUX_ALERT_EN];
  wire [5:0] outside_clock_divider = aux_q[`LAB_AUX_DIV_MSB:`LAB_AUX_DIV_LSB];
  wire       any_flag              = |flags_q;

  assign sda_o = 1'b0;
  assign alert_or_clock_pin_o = 1'b0;

  // word a read returns for a given pointer
  function [15:0] reg_read;
    input [7:0] ofs;
    begin
      case (ofs)
        `LAB_OFS_POWER:     reg_read = power_i;
        `LAB_OFS_CURRENT:   reg_read = current_i;
        `LAB_OFS_SHUNT_LIM: reg_read = shunt_lim_q;
        `LAB_OFS_BUS_LIM:   reg_read = bus_lim_q;
        `LAB_OFS_FLAGS:     reg_read = {12'h000, flags_q};
        `LAB_OFS_AUX:       reg_read = {7'h00, aux_q};
        default:            reg_read = 16'h0000;
      endcase
    end
  endfunction

  // bus limit count in bus reading units: 256 mV is 64 steps of 4 mV
  function [15:0] bus_limit_scaled;
    input [7:0] lim;
    begin
      bus_limit_scaled = {2'b00, lim, 6'h00};
    end
  endfunction

  // shunt limit count in shunt reading units: 2.56 mV is 256 steps of 10 uV
  function [15:0] shunt_limit_scaled;
    input [7:0] lim;
    begin
      shunt_limit_scaled = {lim, 8'h00};
    end
  endfunction

  // pull sda low for a 0 in bit n of the byte being sent, high byte first
  function tx_pull;
    input [15:0] data;
    input        hi;
    input [3:0]  n;
    begin
      tx_pull = hi ? !data[4'hf - n] : !data[4'h7 - n];
    end
  endfunction

  // pins cross into the clock domain through two flops
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      pin_sync_q <= 2'h3;
      por_cnt_q  <= 8'h00;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_i};
      sda_sync_q <= {sda_sync_q[1:0], sda_i};
      pin_sync_q <= {pin_sync_q[0], alert_or_clock_pin_i};
      if (!por_done) begin
        por_cnt_q <= por_cnt_q + 8'h01;
      end
    end
  end

  // next transmit byte after an acknowledge slot of a read
  always @* begin
    next_word = word_q;
    next_hi   = hi_q;
    if (fresh_q) begin
      next_hi = 1'b1;
    end else if (hi_q) begin
      next_hi = 1'b0;
    end else begin
      next_hi   = 1'b1;
      next_word = reg_read(ptr_q + 8'h01);
    end
  end

  // serial slave: bytes, acknowledges and pointer
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q   <= ST_IDLE;
      cnt_q     <= 4'h0;
      shift_q   <= 8'h00;
      ptr_q     <= 8'h00;
      hold_q    <= 8'h00;
      word_q    <= 16'h0000;
      hi_q      <= 1'b1;
      fresh_q   <= 1'b0;
      sda_oe_o  <= 1'b0;
      wr_stb_q  <= 1'b0;
      wr_data_q <= 16'h0000;
    end else begin
      wr_stb_q <= 1'b0;
      if (start_det && por_done) begin
        state_q  <= ST_ADDR;
        cnt_q    <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (stop_det) begin
        state_q  <= ST_IDLE;
        cnt_q    <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (state_q != ST_IDLE) begin
        if (scl_rise && state_q != ST_HOLD) begin
          if (cnt_q < 4'h8) begin
            shift_q <= {shift_q[6:0], sda_s};
            cnt_q   <= cnt_q + 4'h1;
          end else if (cnt_q == 4'h8) begin
            cnt_q <= 4'h9;
            if (state_q == ST_RDATA && sda_s) begin
              state_q <= ST_HOLD;
            end
          end
        end else if (scl_fall) begin
          if (cnt_q == 4'h8) begin
            sda_oe_o <= 1'b0;
            case (state_q)
              ST_ADDR: begin
                if (shift_q[7:1] == slave_addr_i) begin
                  sda_oe_o <= 1'b1;
                  if (shift_q[0]) begin
                    state_q <= ST_RDATA;
                    word_q  <= reg_read(ptr_q);
                    hi_q    <= 1'b1;
                    fresh_q <= 1'b1;
                  end else begin
                    state_q <= ST_PTR;
                  end
                end else begin
                  state_q <= ST_HOLD;
                end
              end
              ST_PTR: begin
                ptr_q    <= shift_q;
                sda_oe_o <= 1'b1;
                state_q  <= ST_WDATA;
                hi_q     <= 1'b1;
              end
              ST_WDATA: begin
                sda_oe_o <= 1'b1;
                if (hi_q) begin
                  hold_q <= shift_q;
                  hi_q   <= 1'b0;
                end else begin
                  wr_stb_q  <= 1'b1;
                  wr_data_q <= {hold_q, shift_q};
                  state_q   <= ST_HOLD;
                end
              end
              ST_RDATA: sda_oe_o <= 1'b0;
              default:  state_q <= ST_HOLD;
            endcase
          end else if (cnt_q == 4'h9) begin
            cnt_q    <= 4'h0;
            sda_oe_o <= 1'b0;
            if (state_q == ST_RDATA) begin
              fresh_q <= 1'b0;
              hi_q    <= next_hi;
              word_q  <= next_word;
              if (!fresh_q && !hi_q) begin
                ptr_q <= ptr_q + 8'h01;
              end
              sda_oe_o <= tx_pull(next_word, next_hi, 4'h0);
            end
          end else if (state_q == ST_RDATA && cnt_q < 4'h8) begin
            sda_oe_o <= tx_pull(word_q, hi_q, cnt_q);
          end
        end
      end
    end
  end

  // limit compares and warning flags
  always @* begin
    flags_set = 4'h0;
    flags_clr = 4'h0;
    if (conv_done_i) begin
      flags_set[`LAB_FLG_BUS_LOW]   = bus_i < bus_limit_scaled(bus_lower_limit);
      flags_set[`LAB_FLG_BUS_HIGH]  = bus_i > bus_limit_scaled(bus_upper_limit);
      flags_set[`LAB_FLG_SHUNT_LOW] = $signed(shunt_i) <
        $signed(shunt_limit_scaled(shunt_lower_limit));
      flags_set[`LAB_FLG_SHUNT_HI]  = $signed(shunt_i) >
        $signed(shunt_limit_scaled(shunt_upper_limit));
    end
    if (wr_stb_q && ptr_q == `LAB_OFS_FLAGS) begin
      flags_clr = wr_data_q[3:0];
    end
  end

  // register writes
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shunt_lim_q <= `LAB_RST_LIMIT;
      bus_lim_q   <= `LAB_RST_LIMIT;
      flags_q     <= `LAB_RST_FLAGS;
      aux_q       <= `LAB_RST_AUX;
    end else begin
      flags_q <= (flags_q & ~flags_clr) | flags_set;
      if (wr_stb_q) begin
        case (ptr_q)
          `LAB_OFS_SHUNT_LIM: shunt_lim_q <= wr_data_q;
          `LAB_OFS_BUS_LIM:   bus_lim_q   <= wr_data_q;
          `LAB_OFS_AUX:       aux_q       <= wr_data_q[8:0];
          default:            aux_q       <= aux_q;
        endcase
      end
    end
  end

  // shared pin: open-drain alert or clock input
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      alert_or_clock_pin_oe_o <= 1'b0;
      osc_run_o               <= 1'b1;
    end else begin
      osc_run_o <= !clk_en;
      if (clk_en) begin
        alert_or_clock_pin_oe_o <= 1'b0;
      end else if (force_alert) begin
        alert_or_clock_pin_oe_o <= 1'b1;
      end else if (alert_enable && any_flag) begin
        alert_or_clock_pin_oe_o <= 1'b1;
      end else begin
        alert_or_clock_pin_oe_o <= 1'b0;
      end
    end
  end

  lab_clk_div u_div (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .en_i      (clk_en),
    .pin_s_i   (pin_sync_q[1]),
    .div_i     (outside_clock_divider),
    .int_clk_o (int_clk_o)
  );
endmodule

// [tb/lab_i2c_master.sv]
// serial bus master model facing the register bank
`timescale 1ns/1ps
module lab_i2c_master #(
  parameter int H = 20
) (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  initial scl_o = 1'b1;
  initial sda_low_o = 1'b0;
  task automatic pins(input logic c, input logic s, input int k);
    scl_o <= c;
    sda_low_o <= ~s;
    repeat (k) @(posedge clk_i);
  endtask
  // data set and held while scl is low
  task automatic bit_io(input logic b, output logic r);
    pins(1'b0, ~sda_low_o, 1);
    pins(1'b0, b, H / 2 - 1);
    pins(1'b1, b, H);
    r = sda_i;
    pins(1'b0, b, H / 2);
  endtask
  // sda falls while scl high
  task automatic start();
    pins(scl_o, 1'b1, H / 2);
    pins(1'b1, 1'b1, H);
    pins(1'b1, 1'b0, H);
  endtask
  // sda rises while scl high, scl then stands high
  task automatic stop();
    pins(1'b0, 1'b0, H / 2);
    pins(1'b1, 1'b0, H);
    pins(1'b1, 1'b1, H);
  endtask
  // eight bits msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] q,
                      output logic r);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ab, r);
  endtask
  // address, pointer, high byte, low byte; n holds the refused bytes
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d,
                    output logic [3:0] n);
    logic [7:0] q;
    start();
    xfer({a, 1'b0}, 1'b1, q, n[3]);
    xfer(p, 1'b1, q, n[2]);
    xfer(d[15:8], 1'b1, q, n[1]);
    xfer(d[7:0], 1'b1, q, n[0]);
    stop();
  endtask
  // pointer, repeated start, high byte acked, low byte refused
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [15:0] d,
                    output logic [2:0] n);
    logic x;
    start();
    xfer({a, 1'b0}, 1'b1, d[7:0], n[2]);
    xfer(p, 1'b1, d[7:0], n[1]);
    start();
    xfer({a, 1'b1}, 1'b1, d[7:0], n[0]);
    xfer(8'hff, 1'b0, d[15:8], x);
    xfer(8'hff, 1'b1, d[7:0], x);
    stop();
  endtask
endmodule

// [tb/lab_bank_monitor.sv]
// assertions on the ports of the limit and alert register bank
`timescale 1ns/1ps
module lab_bank_monitor (
  input wire clk_i,
  input wire nrst_i,
  input wire scl_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire conv_done_i,
  input wire alert_or_clock_pin_o,
  input wire alert_or_clock_pin_oe_o,
  input wire osc_run_o,
  input wire int_clk_o
);
  logic [4:0] por_q;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      por_q <= 5'h00;
    end else if (por_q != 5'h1f) begin
      por_q <= por_q + 5'h01;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  property p_sda0; sda_o == 1'b0; endproperty
  a_sda0: assert property (p_sda0) else $error("sda value not 0");
  property p_pin0; alert_or_clock_pin_o == 1'b0; endproperty
  a_pin0: assert property (p_pin0) else $error("pin value not 0");
  property p_por; por_q < 5'h10 |-> !sda_oe_o; endproperty
  a_por: assert property (p_por) else $error("sda driven in power-up");
  property p_low; $changed(sda_oe_o) |-> !scl_i; endproperty
  a_low: assert property (p_low) else $error("sda moved with scl high");
  property p_hold; $rose(sda_oe_o) |-> sda_oe_o[*8]; endproperty
  a_hold: assert property (p_hold) else $error("sda bit too short");
  property p_ext; !osc_run_o |-> !alert_or_clock_pin_oe_o; endproperty
  a_ext: assert property (p_ext) else $error("pin driven as clock input");
  property p_iclk; osc_run_o && $past(osc_run_o, 3) |-> !int_clk_o; endproperty
  a_iclk: assert property (p_iclk) else $error("divided clock runs");
  property p_conv;
    $rose(alert_or_clock_pin_oe_o) && scl_i |-> $past(conv_done_i, 2) || $past(conv_done_i, 3);
  endproperty
  a_conv: assert property (p_conv) else $error("alert without conversion");
endmodule
bind lab_bank lab_bank_monitor u_mon (.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .conv_done_i(conv_done_i),
  .alert_or_clock_pin_o(alert_or_clock_pin_o), .osc_run_o(osc_run_o),
  .alert_or_clock_pin_oe_o(alert_or_clock_pin_oe_o), .int_clk_o(int_clk_o));

// [tb/tb_limit_alert_register_bank.sv]
// self-checking bench of the limit and alert register bank
`timescale 1ns/1ps
module tb_limit_alert_register_bank;
  localparam logic [6:0] SA = 7'h40;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        conv_done_i = 1'b0;
  logic [15:0] shunt_i = 16'h0000;
  logic [15:0] bus_i = 16'h0000;
  logic [15:0] power_i = 16'h8001;
  logic [15:0] current_i = 16'hfffe;
  logic        pin_drv = 1'b1;
  logic        scl, sda_low, sda_oe, pin_oe, osc, iclk;
  logic [15:0] d;
  logic [3:0]  n;
  logic [2:0]  r;
  int          num_errors = 0;
  int          comparisons = 0;
  wire         sda = ~(sda_low | sda_oe);
  wire         pin = pin_oe ? 1'b0 : pin_drv;
  always #12.5 clk_i = ~clk_i;
  lab_bank dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe_o(sda_oe), .slave_addr_i(SA), .conv_done_i(conv_done_i), .shunt_i(shunt_i),
    .bus_i(bus_i), .power_i(power_i), .current_i(current_i), .alert_or_clock_pin_i(pin),
    .alert_or_clock_pin_o(), .alert_or_clock_pin_oe_o(pin_oe), .osc_run_o(osc),
    .int_clk_o(iclk));
  lab_i2c_master m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic w(input logic [7:0] p, input logic [15:0] v);
    m.wr(SA, p, v, n);
    check(n, 4'h0);
  endtask
  task automatic rc(input logic [7:0] p, input logic [15:0] v);
    m.rd(SA, p, d, r);
    check(r, 3'h0);
    check(d, v);
  endtask
  task automatic conv(input logic [15:0] s, input logic [15:0] b);
    shunt_i <= s;
    bus_i <= b;
    conv_done_i <= 1'b1;
    @(posedge clk_i);
    conv_done_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic t_regs();
    for (int i = 6; i <= 9; i++) rc(i[7:0], 16'h0000);
    w(8'h06, 16'h807f);
    rc(8'h06, 16'h807f);
    w(8'h07, 16'hff01);
    rc(8'h07, 16'hff01);
    w(8'h08, 16'hfff0);
    rc(8'h08, 16'h0000);
    m.wr(SA ^ 7'h01, 8'h06, 16'h1234, n);
    check(n, 4'hf);
    rc(8'h06, 16'h807f);
    rc(8'h03, power_i);
    rc(8'h04, current_i);
    m.wr(SA, 8'h03, 16'h0000, n);
    rc(8'h03, 16'h8001);
    rc(8'h0a, 16'h0000);
  endtask
  task automatic t_flags();
    w(8'h06, 16'h01ff);
    w(8'h07, 16'h0402);
    shunt_i <= 16'h7fff;
    rc(8'h08, 16'h0000);
    conv(16'h0100, 16'h0100);
    rc(8'h08, 16'h0000);
    conv(16'h0101, 16'h007f);
    rc(8'h08, 16'h0009);
    conv(16'h0000, 16'h00c0);
    rc(8'h08, 16'h0009);
    conv(16'hfeff, 16'h0101);
    rc(8'h08, 16'h000f);
    check(pin_oe, 1'b0);
    w(8'h08, 16'h0005);
    rc(8'h08, 16'h000a);
    w(8'h08, 16'h000a);
    rc(8'h08, 16'h0000);
  endtask
  task automatic t_alert();
    int   k;
    logic prev;
    k = 0;
    prev = 1'b0;
    w(8'h09, 16'h0080);
    conv(16'h0101, 16'h0100);
    check(pin_oe, 1'b1);
    w(8'h08, 16'h0008);
    check(pin_oe, 1'b0);
    w(8'h09, 16'h0100);
    check(pin_oe, 1'b1);
    rc(8'h09, 16'h0100);
    w(8'h09, 16'h0042);
    check({osc, pin_oe}, 2'b00);
    for (int i = 0; i < 288; i++) begin
      pin_drv <= i[2];
      @(negedge clk_i);
      if (iclk && !prev) k++;
      prev = iclk;
      @(posedge clk_i);
    end
    check(k[15:0], 16'h0006);
    pin_drv <= 1'b1;
    w(8'h09, 16'h0000);
    check({osc, pin_oe}, 2'b10);
  endtask
  // two words in one read: the pointer steps on to the next register
  task automatic t_burst();
    logic [15:0] q;
    logic        x;
    m.start();
    m.xfer({SA, 1'b0}, 1'b1, q[7:0], x);
    m.xfer(8'h06, 1'b1, q[7:0], x);
    m.start();
    m.xfer({SA, 1'b1}, 1'b1, q[7:0], x);
    m.xfer(8'hff, 1'b0, d[15:8], x);
    m.xfer(8'hff, 1'b0, d[7:0], x);
    m.xfer(8'hff, 1'b0, q[15:8], x);
    m.xfer(8'hff, 1'b1, q[7:0], x);
    m.stop();
    check(d, 16'h807f);
    check(q, 16'hff01);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (30) @(posedge clk_i);
    check({osc, pin_oe, sda_oe}, 3'b100);
    t_regs();
    t_burst();
    t_flags();
    t_alert();
    end_of_test();
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    num_errors++;
    end_of_test();
  end
endmodule
